// *** core/scid_map.vh ***
// Purpose: register offsets, field positions, reset values and timing for the config port
// Assumes: ref_clk at 10 MHz; offsets are byte addresses on the serial port
// Notes: included by scid_spi_regs.v only
`ifndef SCID_MAP_VH
`define SCID_MAP_VH
`define SCID_ADDR_W 15
`define SCID_OFS_IFCFG 15'h0000
`define SCID_OFS_OPSTATE 15'h0002
`define SCID_OFS_CLASS 15'h0003
`define SCID_OFS_FAMILY_LO 15'h0004
`define SCID_OFS_FAMILY_HI 15'h0005
`define SCID_OFS_MAKER_LO 15'h000c
`define SCID_OFS_MAKER_HI 15'h000d
`define SCID_OFS_USER 15'h0010
`define SCID_BIT_SOFTRST 7
`define SCID_BIT_ASCEND 5
`define SCID_BIT_SEPOUT 4
`define SCID_BIT_HOLD 0
`define SCID_IFCFG_RESET 8'h30
`define SCID_OPSTATE_RESET 8'h00
`define SCID_USER_RESET 8'h00
`define SCID_MODE_NORMAL 2'h0
`define SCID_MODE_PWRDN 2'h3
`define SCID_SOFTRST_NS 750
`define SCID_CLK_MHZ 10
`define SCID_SOFTRST_CYC ((`SCID_SOFTRST_NS * `SCID_CLK_MHZ) / 1000)
`define SCID_HDR_BITS 16
`endif

// *** core/scid_spi_regs.v ***
// Purpose: serial configuration port with config, operating-state and identity registers
// Assumes: spi mode 0, msb first, 16-bit header (rw, 15-bit address) then data bytes;
//   sclk slower than ref_clk / 4 since pins are oversampled
// Notes: soft reset holds the port idle for the reset interval
`include "scid_map.vh"
module scid_spi_regs #(
  parameter [3:0] CLASS_CODE = 4'h5, // arbitrary value
  parameter [15:0] FAMILY_CODE = 16'h00a7, // arbitrary value
  parameter [15:0] MAKER_CODE = 16'h0b3c // arbitrary value
) (
  input wire ref_clk,
  input wire srst,
  input wire spiCsN,
  input wire spiSclk,
  input wire spiSdi,
  output reg spiSdo,
  output wire spiSdoOeN,
  output wire chipResetActive,
  output wire powerDown
);
  localparam [31:0] RST_CYC_ALL = `SCID_SOFTRST_CYC;
  // the interval fits three bits at 10 MHz; a faster ref_clk needs a wider counter
  localparam [2:0] RST_CYC = RST_CYC_ALL[2:0];
  localparam [31:0] HDR_LAST_ALL = `SCID_HDR_BITS - 1;
  localparam [4:0] HDR_LAST = HDR_LAST_ALL[4:0];
  localparam [7:0] IFCFG_RST = `SCID_IFCFG_RESET;
  localparam [7:0] OPSTATE_RST = `SCID_OPSTATE_RESET;
  // one-hot phases of a frame
  localparam [1:0] ST_HDR = 2'b01;
  localparam [1:0] ST_DATA = 2'b10;

  reg [1:0] csSync;
  reg [1:0] sclkSync;
  reg [1:0] sdiSync;
  reg sclkLast;
  wire csN = csSync[1];
  wire sclkRise = sclkSync[1] & ~sclkLast;
  wire sclkFall = ~sclkSync[1] & sclkLast;

  // writable register bits
  reg ifcfgRsvd6;
  reg ascend;
  reg [3:0] ifcfgLow;
  reg [7:0] opState;
  reg [3:0] classRsvd;
  reg [7:0] userCfg;
  reg pdFlag;

  reg [2:0] rstCnt;
  reg rstBusy;
  reg [4:0] hdrCnt;
  reg [15:0] hdrShift;
  reg isRead;
  reg [14:0] addr;
  reg [3:0] bitInByte;
  reg [6:0] inShift;
  reg [7:0] outShift;
  reg [1:0] phase;
  wire dataPhase = (phase == ST_DATA);

  function [7:0] readByte;
    input [14:0] a;
    begin
      case (a)
        `SCID_OFS_IFCFG: readByte = {1'b0, ifcfgRsvd6, ascend, 1'b1, ifcfgLow};
        `SCID_OFS_OPSTATE: readByte = opState;
        `SCID_OFS_CLASS: readByte = {classRsvd, CLASS_CODE};
        `SCID_OFS_FAMILY_LO: readByte = FAMILY_CODE[7:0];
        `SCID_OFS_FAMILY_HI: readByte = FAMILY_CODE[15:8];
        `SCID_OFS_MAKER_LO: readByte = MAKER_CODE[7:0];
        `SCID_OFS_MAKER_HI: readByte = MAKER_CODE[15:8];
        `SCID_OFS_USER: readByte = userCfg;
        default: readByte = 8'h00;
      endcase
    end
  endfunction

  // next streaming address
  function [14:0] stepAddr;
    input [14:0] a;
    input hold;
    input up;
    begin
      if (hold) begin
        stepAddr = a;
      end else if (up) begin
        stepAddr = a + 15'h0001;
      end else begin
        stepAddr = a - 15'h0001;
      end
    end
  endfunction

  wire [7:0] wrByte = {inShift, sdiSync[1]};
  wire byteDone = dataPhase & sclkRise & ~csN & (bitInByte == 4'h7);
  wire doWrite = byteDone & ~isRead;
  wire softRstReq = doWrite & (addr == `SCID_OFS_IFCFG) & wrByte[`SCID_BIT_SOFTRST];
  wire regReset = srst | softRstReq;
  wire [14:0] hdrAddr = {hdrShift[13:0], sdiSync[1]};
  wire [7:0] hdrByte = readByte(hdrAddr);
  wire hdrLast = ~dataPhase & sclkRise & (hdrCnt == HDR_LAST);
  wire [14:0] nextAddr = stepAddr(addr, userCfg[`SCID_BIT_HOLD], ascend);
  wire [7:0] nextByte = readByte(nextAddr);

  always @(posedge ref_clk) begin
    if (srst) begin
      csSync <= 2'h3;
      sclkSync <= 2'h0;
      sdiSync <= 2'h0;
      sclkLast <= 1'b0;
    end else begin
      csSync <= {csSync[0], spiCsN};
      sclkSync <= {sclkSync[0], spiSclk};
      sdiSync <= {sdiSync[0], spiSdi};
      sclkLast <= sclkSync[1];
    end
  end

  // soft reset interval; bit 7 never stores, so it reads back as zero
  always @(posedge ref_clk) begin
    if (srst) begin
      rstBusy <= 1'b0;
      rstCnt <= 3'h0;
    end else if (softRstReq) begin
      rstBusy <= 1'b1;
      rstCnt <= RST_CYC;
    end else if (rstBusy) begin
      if (rstCnt == 3'h1) begin
        rstBusy <= 1'b0;
      end
      rstCnt <= rstCnt - 3'h1;
    end
  end

  always @(posedge ref_clk) begin
    if (regReset) begin
      ifcfgRsvd6 <= IFCFG_RST[6];
      ascend <= IFCFG_RST[`SCID_BIT_ASCEND];
      ifcfgLow <= IFCFG_RST[3:0];
      opState <= OPSTATE_RST;
      pdFlag <= (OPSTATE_RST[1:0] == `SCID_MODE_PWRDN);
      classRsvd <= 4'h0;
      userCfg <= `SCID_USER_RESET;
    end else if (doWrite) begin
      case (addr)
        `SCID_OFS_IFCFG: begin
          ifcfgRsvd6 <= wrByte[6];
          ascend <= wrByte[`SCID_BIT_ASCEND];
          ifcfgLow <= wrByte[3:0];
        end
        `SCID_OFS_OPSTATE: begin
          opState <= wrByte;
          pdFlag <= (wrByte[1:0] == `SCID_MODE_PWRDN);
        end
        `SCID_OFS_CLASS: classRsvd <= wrByte[7:4];
        `SCID_OFS_USER: userCfg <= wrByte;
        default: ;
      endcase
    end
  end

  // serial engine; a dropped chip select abandons any partial byte
  always @(posedge ref_clk) begin
    if (regReset | rstBusy | csN) begin
      phase <= ST_HDR;
      hdrCnt <= 5'h0;
      hdrShift <= 16'h0000;
      isRead <= 1'b0;
      addr <= 15'h0000;
      bitInByte <= 4'h0;
      inShift <= 7'h00;
    end else begin
      case (phase)
        ST_HDR: begin
          if (sclkRise) begin
            hdrShift <= {hdrShift[14:0], sdiSync[1]};
            hdrCnt <= hdrCnt + 5'h01;
            if (hdrCnt == HDR_LAST) begin
              isRead <= hdrShift[14];
              addr <= hdrAddr;
              phase <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (sclkRise) begin
            inShift <= {inShift[5:0], sdiSync[1]};
            if (bitInByte == 4'h7) begin
              bitInByte <= 4'h0;
              addr <= nextAddr;
            end else begin
              bitInByte <= bitInByte + 4'h1;
            end
          end
        end
        default: phase <= ST_HDR;
      endcase
    end
  end

  // read shifter: a byte loaded on the rise that ends the one before is held back
  // until the next fall; the first bit of a frame is driven on the last header rise, and each later bit stands from one fall to the next
  always @(posedge ref_clk) begin
    if (regReset | rstBusy | csN) begin
      outShift <= 8'h00;
      spiSdo <= 1'b0;
    end else if (hdrLast) begin
      outShift <= hdrByte;
      spiSdo <= hdrByte[7];
    end else if (dataPhase & sclkRise & (bitInByte == 4'h7)) begin
      outShift <= nextByte;
    end else if (dataPhase & sclkFall) begin
      if (bitInByte == 4'h0) begin
        spiSdo <= outShift[7];
      end else begin
        outShift <= {outShift[6:0], 1'b0};
        spiSdo <= outShift[6];
      end
    end
  end

  assign spiSdoOeN = ~(dataPhase & isRead & ~csN);
  assign chipResetActive = rstBusy;
  assign powerDown = pdFlag;
endmodule

// *** test/scid_host_model.sv ***
// Purpose: spi host model for the config port, mode 0, msb first
// Assumes: sclk half period of 4 ref_clk; pins move on ref_clk fall
// Notes: sdi flips between frames so stale data never looks valid
module scid_host_model (
  input wire logic ref_clk,
  output logic spiCsN,
  output logic spiSclk,
  output logic spiSdi,
  input wire logic spiSdo,
  input wire logic spiSdoOeN
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    spiCsN = 1'b1;
    spiSclk = 1'b0;
    spiSdi = 1'b0;
  end
  task automatic frame(input logic [47:0] cmd, input int n, output logic [15:0] q);
    q = 16'h0000;
    @(negedge ref_clk);
    spiCsN = 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      spiSdi = cmd[47 - i];
      repeat (4) @(negedge ref_clk);
      if (i >= 16) q = {q[14:0], spiSdoOeN ? 1'bx : spiSdo};
      spiSclk = 1'b1;
      repeat (4) @(negedge ref_clk);
      spiSclk = 1'b0;
    end
    spiCsN = 1'b1;
    spiSdi = ~spiSdi;
    // gap also outlasts the soft reset interval
    repeat (8) @(negedge ref_clk);
  endtask
endmodule

// *** test/scid_spi_regs_props.sv ***
// Purpose: port properties of the config register port
// Assumes: one clock, srst synchronous active high
// Notes: sdo margins assume sclk half periods of 4 ref_clk
module scid_spi_regs_props (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic spiCsN,
  input wire logic spiSclk,
  input wire logic spiSdo,
  input wire logic spiSdoOeN,
  input wire logic chipResetActive,
  input wire logic powerDown
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  sequence softResetPulse;
    chipResetActive [*7] ##1 !chipResetActive;
  endsequence
  AST_RST_LEN: assert property ($rose(chipResetActive) |-> softResetPulse)
    else $error("bad soft reset length");
  AST_RST_CLEARS: assert property ($rose(chipResetActive) |-> !powerDown)
    else $error("power-down kept over soft reset");
  AST_RST_IDLE: assert property (chipResetActive |-> spiSdoOeN)
    else $error("sdo driven in soft reset");
  AST_SRST_OUT: assert property ($fell(srst) |-> spiSdoOeN && !powerDown)
    else $error("outputs not at reset level");
  AST_OE_CS: assert property (spiCsN [*3] |-> spiSdoOeN)
    else $error("sdo driven while deselected");
  AST_OE_HDR: assert property ($fell(spiCsN) |=> spiSdoOeN [*8])
    else $error("sdo driven in header");
  AST_SDO_HOLD: assert property ($rose(spiSclk) && !spiSdoOeN |=> $stable(spiSdo) [*4])
    else $error("sdo moved before sclk fall");
  AST_PD_IDLE: assert property (spiCsN [*6] |-> $stable(powerDown))
    else $error("power-down moved between frames");
endmodule
bind scid_spi_regs scid_spi_regs_props u_scid_spi_regs_props (.ref_clk(ref_clk), .srst(srst),
  .spiCsN(spiCsN), .spiSclk(spiSclk), .spiSdo(spiSdo), .spiSdoOeN(spiSdoOeN),
  .chipResetActive(chipResetActive), .powerDown(powerDown));

// *** test/spi_config_id_registers_bench.sv ***
// Purpose: self-checking bench for the config register port
// Assumes: default id parameters of the design
// Notes: row = kind, addr, bytes, power-down, write byte, read value
module spi_config_id_registers_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  wire spiCsN, spiSclk, spiSdi, spiSdo, spiSdoOeN, chipResetActive, powerDown;
  int num_errors = 0;
  int samples_checked = 0;
  int busyCycles = 0;
  logic [15:0] q;
  logic [47:0] rows [19];
  scid_spi_regs u_scid_spi_regs (.ref_clk(ref_clk), .srst(srst), .spiCsN(spiCsN),
    .spiSclk(spiSclk), .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOeN(spiSdoOeN),
    .chipResetActive(chipResetActive), .powerDown(powerDown));
  scid_host_model u_scid_host_model (.ref_clk(ref_clk), .spiCsN(spiCsN), .spiSclk(spiSclk),
    .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOeN(spiSdoOeN));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial forever #50 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (chipResetActive) busyCycles++;
  initial begin
    #2000000;
    num_errors++;
    end_of_test;
  end
  initial begin
    rows = '{48'h1_000_1_0_00_0030, 48'h1_002_1_0_00_0000, 48'h1_003_1_0_00_0005,
      48'h1_004_2_0_00_a700, 48'h1_00c_2_0_00_3c0b, 48'h0_004_1_0_ff_0000,
      48'h1_004_1_0_00_00a7, 48'h0_002_1_1_03_0000, 48'h1_002_1_1_00_0003,
      48'h0_002_1_0_01_0000, 48'h0_000_1_0_4f_0000, 48'h1_000_1_0_00_005f,
      48'h1_003_2_0_00_0501, 48'h0_010_1_0_01_0000, 48'h1_003_2_0_00_0505,
      48'h0_002_1_1_03_0000, 48'h0_000_1_0_80_0000, 48'h1_000_1_0_00_0030,
      48'h1_010_1_0_00_0000};
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    repeat (3) @(negedge ref_clk);
    foreach (rows[i]) begin
      u_scid_host_model.frame({rows[i][44], 3'h0, rows[i][43:32], rows[i][23:16], 24'h0},
        int'(rows[i][31:28]), q);
      if (rows[i][44]) check(q, rows[i][15:0]);
      check({15'h0000, powerDown}, {12'h000, rows[i][27:24]});
      $display("row %0d done", i);
    end
    check(busyCycles[15:0], 16'h0007);
    u_scid_host_model.frame(48'h0002_0300_0000, 1, q);
    check({15'h0000, powerDown}, 16'h0001);
    srst = 1'b1;
    repeat (3) @(negedge ref_clk);
    srst = 1'b0;
    repeat (3) @(negedge ref_clk);
    check({15'h0000, powerDown}, 16'h0000);
    u_scid_host_model.frame(48'h8000_0000_0000, 1, q);
    check(q, 16'h0030);
    $display("mid-run reset done");
    end_of_test;
  end
endmodule
